// File: hw/usbep_dev.sv
/*
 * Endpoint status/control register bits (upper five) and the handshake
 * decisions they steer, for all endpoints.
 * Assumes the packet engine and configuration inputs share clk_i.
 */
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
// Functional notes
// R1: Direction bit honoured only on control endpoints
// R2: Direction bit selects status phase direction
// R3: Firmware sets direction first on setup interrupt
// R4: Firmware clears direction for control OUT status; here OUT status (status_out) needs the direction bit set
// R5: Bank-1 store sets flag, raises interrupt
// R6: Bank-1 flag set NAKs OUT, not isochronous
// R7: Firmware clears bank-1 flag after reading FIFO
// R8: Stall request gives STALL handshake until cleared
// R9: Firmware fills FIFO only while ready clear
// R10: Ready with empty FIFO sends zero-length packet
// R11: Firmware ends max-size transfers with zero-length
// R12: Ready clears on send (iso) or ACK
// R13: STALL sent sets stall-sent flag, interrupt
// R14: SETUP received clears stall-sent flag
// R15: Isochronous CRC error sets same flag, interrupt
// R16: Endpoint type: control, iso, bulk, interrupt
// R17: Access goes to the selected endpoint
`timescale 1ns/10ps
module usbep_dev
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    usbep_if.dev bus,
    input wire usbep_pkg::usbep_eptype_t [usbep_pkg::EP_COUNT-1:0] ep_type_i,
    input wire logic [usbep_pkg::EP_COUNT-1:0] ep_int_en_i,
    input wire logic [usbep_pkg::EP_COUNT-1:0] pingpong_en_i,
    input wire logic ev_valid_i,
    input wire logic [usbep_pkg::EP_W-1:0] ev_ep_i,
    input wire usbep_pkg::usbep_ev_t ev_code_i,
    input wire logic tok_valid_i,
    input wire logic [usbep_pkg::EP_W-1:0] tok_ep_i,
    input wire usbep_pkg::usbep_tok_t tok_pid_i,
    input wire logic tok_bank1_i,
    input wire logic tok_fifo_empty_i,
    output logic hs_valid_o,
    output usbep_pkg::usbep_hs_t hs_code_o,
    output logic zlp_o,
    output logic [usbep_pkg::EP_COUNT-1:0] status_out_o
);
    import usbep_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        usbep_epst_t [EP_COUNT-1:0] ep;
        logic [7:0] rdata;
        logic rvalid;
        logic [EP_COUNT-1:0] irq;
        logic hs_valid;
        usbep_hs_t hs_code;
        logic zlp;
        logic [EP_COUNT-1:0] status_out;
    } usbep_dev_st_t;

    usbep_dev_st_t st;
    usbep_dev_st_t next_st;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Order matters: firmware write first, hardware events after, so a
    // hardware set in the same cycle as a firmware clear survives.
    always_comb
    begin
        usbep_eptype_t ev_type;
        usbep_eptype_t tok_type;
        usbep_epst_t cur;
        logic ev_ok;
        logic tok_ok;
        ev_type = EPT_CONTROL;
        tok_type = EPT_CONTROL;
        cur = '0;
        ev_ok = 1'b0;
        tok_ok = 1'b0;
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.hs_valid = 1'b0;

        // Firmware write to the selected endpoint
        if (bus.wr && (bus.sel < EP_COUNT)) // [R17]
        begin
            next_st.ep[bus.sel].dir = bus.wdata[BIT_DIR]; // [R3] [R4]
            next_st.ep[bus.sel].stall = bus.wdata[BIT_STALL]; // [R8]
            next_st.ep[bus.sel].in_packet_ready = bus.wdata[BIT_IN_PACKET_READY]; // [R9]
            // Software can only clear the flags (SETUP also clears stall-sent), writing one keeps them
            next_st.ep[bus.sel].b1 = st.ep[bus.sel].b1 & bus.wdata[BIT_B1]; // [R7]
            next_st.ep[bus.sel].stall_sent_or_crc_error = st.ep[bus.sel].stall_sent_or_crc_error & bus.wdata[BIT_STALL_SENT_OR_CRC_ERROR];
        end

        // Firmware read; unmapped endpoint reads zero
        if (bus.rd)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata = 8'h00;
            if (bus.sel < EP_COUNT) // [R17]
            begin
                cur = st.ep[bus.sel];
                next_st.rdata = {cur.dir, cur.b1, cur.stall, cur.in_packet_ready, cur.stall_sent_or_crc_error,
                                 LOW_BITS_READ};
            end
        end

        // Packet engine events
        ev_ok = ev_valid_i && (ev_ep_i < EP_COUNT);
        if (ev_ok)
        begin
            ev_type = ep_type_i[ev_ep_i]; // [R16]
            case (ev_code_i)
                EV_OUT_B1_STORED:
                begin
                    // Only endpoints 1 and 2 own a second bank
                    if (pingpong_en_i[ev_ep_i] && (ev_ep_i >= PINGPONG_EP_LO)
                        && (ev_ep_i <= PINGPONG_EP_HI))
                    begin
                        next_st.ep[ev_ep_i].b1 = 1'b1; // [R5]
                    end
                end
                EV_CRC_ERR:
                begin
                    if (ev_type == EPT_ISO)
                    begin
                        next_st.ep[ev_ep_i].stall_sent_or_crc_error = 1'b1; // [R15]
                    end
                end
                EV_IN_SENT:
                begin
                    if (ev_type == EPT_ISO)
                    begin
                        next_st.ep[ev_ep_i].in_packet_ready = 1'b0; // [R12]
                    end
                end
                EV_IN_ACKED:
                begin
                    if (ev_type != EPT_ISO)
                    begin
                        next_st.ep[ev_ep_i].in_packet_ready = 1'b0; // [R12]
                    end
                end
                EV_STALL_SENT:
                begin
                    if ((ev_type != EPT_ISO) && st.ep[ev_ep_i].stall)
                    begin
                        next_st.ep[ev_ep_i].stall_sent_or_crc_error = 1'b1; // [R13]
                    end
                end
                default:
                begin
                    next_st.ep[ev_ep_i] = next_st.ep[ev_ep_i];
                end
            endcase
        end

        // Handshake decision for a token
        tok_ok = tok_valid_i && (tok_ep_i < EP_COUNT);
        if (tok_ok)
        begin
            next_st.hs_valid = 1'b1;
            next_st.zlp = 1'b0;
            tok_type = ep_type_i[tok_ep_i]; // [R16]
            cur = st.ep[tok_ep_i];
            case (tok_pid_i)
                TOK_SETUP:
                begin
                    next_st.hs_code = HS_ACK;
                    // Setup wins over any stall-sent set this cycle
                    if (tok_type != EPT_ISO)
                    begin
                        next_st.ep[tok_ep_i].stall_sent_or_crc_error = 1'b0; // [R14]
                    end
                end
                TOK_OUT:
                begin
                    if (tok_type == EPT_ISO)
                        next_st.hs_code = HS_NONE;
                    else if (cur.stall)
                        next_st.hs_code = HS_STALL; // [R8]
                    else if (tok_bank1_i && cur.b1)
                        next_st.hs_code = HS_NAK; // [R6]
                    else
                        next_st.hs_code = HS_ACK;
                end
                TOK_IN:
                begin
                    if ((tok_type != EPT_ISO) && cur.stall)
                        next_st.hs_code = HS_STALL; // [R8]
                    else if (cur.in_packet_ready)
                    begin
                        next_st.hs_code = HS_DATA;
                        next_st.zlp = tok_fifo_empty_i; // [R10]
                    end
                    else if (tok_type == EPT_ISO)
                        next_st.hs_code = HS_NONE;
                    else
                        next_st.hs_code = HS_NAK;
                end
                default:
                begin
                    next_st.hs_code = HS_NONE;
                end
            endcase
        end

        // Per-endpoint interrupt and status direction
        for (int i = 0; i < EP_COUNT; i++)
        begin
            next_st.irq[i] = ep_int_en_i[i]
                & (next_st.ep[i].b1 | next_st.ep[i].stall_sent_or_crc_error); // [R5] [R13] [R15]
            // Data stage IN (dir set) means an OUT status phase
            next_st.status_out[i] = (ep_type_i[i] == EPT_CONTROL)
                & next_st.ep[i].dir; // [R1] [R2]
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign bus.rdata = st.rdata;
    assign bus.rvalid = st.rvalid;
    assign bus.ep_irq = st.irq;
    assign hs_valid_o = st.hs_valid;
    assign hs_code_o = st.hs_code;
    assign zlp_o = st.zlp;
    assign status_out_o = st.status_out;

endmodule : usbep_dev

// File: pkg/usbep_pkg.sv
/*
 * Shared constants and types for the endpoint status/control logic and its
 * register-side controller.
 * Assumes one 100 MHz clock for both ends and a packet engine on the same clock.
 */
package usbep_pkg;

    // ------------------------------------------------------------------
    // Endpoint set
    // ------------------------------------------------------------------
    localparam int EP_COUNT = 3;
    localparam int EP_W = 2;
    localparam logic [EP_W-1:0] PINGPONG_EP_LO = 2'h1;
    localparam logic [EP_W-1:0] PINGPONG_EP_HI = 2'h2;

    // ------------------------------------------------------------------
    // endpoint_status_control bit positions (low three bits read zero)
    // ------------------------------------------------------------------
    localparam int BIT_DIR = 7;
    localparam int BIT_B1 = 6;
    localparam int BIT_STALL = 5;
    localparam int BIT_IN_PACKET_READY = 4;
    localparam int BIT_STALL_SENT_OR_CRC_ERROR = 3;
    localparam logic [2:0] LOW_BITS_READ = 3'h0;
    localparam logic RST_BIT = 1'b0;

    // ------------------------------------------------------------------
    // Endpoint type encoding, tokens, events, handshakes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        EPT_CONTROL = 2'h0,
        EPT_ISO = 2'h1,
        EPT_BULK = 2'h2,
        EPT_INTR = 2'h3
    } usbep_eptype_t;

    typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} usbep_tok_t;

    typedef enum logic [2:0] {
        EV_NONE, EV_OUT_B1_STORED, EV_CRC_ERR, EV_IN_SENT, EV_IN_ACKED, EV_STALL_SENT
    } usbep_ev_t;

    typedef enum logic [2:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL, HS_DATA} usbep_hs_t;

    typedef struct packed {
        logic dir;
        logic b1;
        logic stall;
        logic in_packet_ready;
        logic stall_sent_or_crc_error;
    } usbep_epst_t;

    // ------------------------------------------------------------------
    // Controller registers on AHB-Lite (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ACCESS = 8'h00;
    localparam logic [7:0] OFS_RESULT = 8'h04;
    localparam logic [7:0] OFS_INT_STATUS = 8'h08;
    localparam logic [7:0] OFS_INT_MASK = 8'h0C;
    localparam int ACC_EP_LSB = 8;
    localparam int ACC_WRITE_BIT = 16;
    localparam int RES_BUSY_BIT = 8;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_EP_LSB = 1;
    localparam int INT_W = 4;
    localparam logic [INT_W-1:0] INT_RST = 4'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage : usbep_pkg

// File: pkg/usbep_if.sv
/*
 * Register-side link between the controller and the endpoint logic.
 * Assumes both ends run on the same clock; strobes are one-cycle pulses.
 */
`timescale 1ns/10ps
interface usbep_if;
    import usbep_pkg::*;

    logic [EP_W-1:0] sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic [EP_COUNT-1:0] ep_irq;

    // Endpoint logic end
    modport dev (input sel, input wr, input rd, input wdata,
                 output rdata, output rvalid, output ep_irq);
    // Controller end
    modport ctl (output sel, output wr, output rd, output wdata,
                 input rdata, input rvalid, input ep_irq);
endinterface : usbep_if

// File: hw/usbep_ctl.sv
/*
 * Controller end: AHB-Lite slave holding access, result, interrupt status
 * and mask registers; drives single accesses to the endpoint logic.
 * Assumes one AHB-Lite master and the endpoint logic on clk_i.
 */
`timescale 1ns/10ps
module usbep_ctl
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    usbep_if.ctl bus,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic irq_o
);
    import usbep_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic dp_wr;
        logic [7:0] dp_ofs;
        logic [31:0] hrdata;
        logic [EP_W-1:0] sel;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic busy;
        logic [7:0] result;
        logic [INT_W-1:0] int_status;
        logic [INT_W-1:0] int_mask;
        logic [EP_COUNT-1:0] irq_prev;
        logic irq;
    } usbep_ctl_st_t;

    usbep_ctl_st_t st;
    usbep_ctl_st_t next_st;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [INT_W-1:0] events;
        logic addr_ok;
        events = '0;
        addr_ok = hsel_i && htrans_i[1] && hready_i;
        next_st = st;
        next_st.wr = 1'b0;
        next_st.rd = 1'b0;
        next_st.dp_wr = 1'b0;

        // Address phase: latch write target, prepare read data now
        if (addr_ok)
        begin
            next_st.dp_wr = hwrite_i;
            next_st.dp_ofs = haddr_i[7:0];
            next_st.hrdata = WORD_ZERO;
            if (!hwrite_i)
            begin
                case (haddr_i[7:0])
                    OFS_RESULT: next_st.hrdata = {23'h0, st.busy, st.result};
                    OFS_INT_STATUS: next_st.hrdata = {28'h0, st.int_status};
                    OFS_INT_MASK: next_st.hrdata = {28'h0, st.int_mask};
                    default: next_st.hrdata = WORD_ZERO;
                endcase
            end
        end

        // Data phase of a write; ACCESS ignored while an access is busy
        if (st.dp_wr)
        begin
            case (st.dp_ofs)
                OFS_ACCESS:
                begin
                    if (!st.busy)
                    begin
                        next_st.sel = hwdata_i[ACC_EP_LSB +: EP_W];
                        next_st.wdata = hwdata_i[7:0];
                        next_st.wr = hwdata_i[ACC_WRITE_BIT];
                        next_st.rd = !hwdata_i[ACC_WRITE_BIT];
                        next_st.busy = !hwdata_i[ACC_WRITE_BIT];
                    end
                end
                OFS_INT_STATUS: next_st.int_status = st.int_status & ~hwdata_i[INT_W-1:0];
                OFS_INT_MASK: next_st.int_mask = hwdata_i[INT_W-1:0];
                default: next_st.int_mask = next_st.int_mask;
            endcase
        end

        // Read answer from the endpoint logic
        if (bus.rvalid)
        begin
            next_st.result = bus.rdata;
            next_st.busy = 1'b0;
        end

        // Events after the clear so a same-cycle event is kept
        events[INT_DONE_BIT] = bus.rvalid;
        events[INT_EP_LSB +: EP_COUNT] = bus.ep_irq & ~st.irq_prev;
        next_st.irq_prev = bus.ep_irq;
        next_st.int_status = next_st.int_status | events;
        next_st.irq = |(next_st.int_status & next_st.int_mask);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = st.hrdata;
    assign irq_o = st.irq;
    assign bus.sel = st.sel;
    assign bus.wr = st.wr;
    assign bus.rd = st.rd;
    assign bus.wdata = st.wdata;

endmodule : usbep_ctl

// File: dv/usbep_asserts.sv
/*
 * Checker for the link between the controller and the endpoint logic.
 * Assumes one clock; takes the link signals as plain inputs.
 */
`timescale 1ns/10ps
module usbep_asserts
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [usbep_pkg::EP_W-1:0] sel_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    input wire logic [usbep_pkg::EP_COUNT-1:0] ep_irq_i
);
    import usbep_pkg::*;

    // -------------------------------------------------------------
    // Reference copies
    // -------------------------------------------------------------
    // Last firmware value per endpoint; hardware never moves these bits,
    // so any gap between write and read is covered, not a fixed spacing
    logic [(1<<EP_W)-1:0] stall_w;
    logic [(1<<EP_W)-1:0] dir_w;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            stall_w <= '0;
            dir_w <= '0;
        end
        else if (wr_i)
        begin
            stall_w[sel_i] <= wdata_i[BIT_STALL];
            dir_w[sel_i] <= wdata_i[BIT_DIR];
        end
    end

    // -------------------------------------------------------------
    // Link properties
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // Read of a present endpoint, then its answer one cycle later
    sequence s_rd_present;
        rd_i && sel_i != 2'h3 ##1 rvalid_i;
    endsequence

    a_rd_answer: assert property (rd_i |=> rvalid_i)
        else $error("read strobe got no answer");
    a_rvalid_cause: assert property (rvalid_i |-> $past(rd_i))
        else $error("answer without read strobe");
    a_rvalid_pulse: assert property (rvalid_i |=> !rvalid_i)
        else $error("answer longer than one cycle");
    a_low_bits: assert property (rvalid_i |-> rdata_i[2:0] == LOW_BITS_READ)
        else $error("low read bits not zero");
    a_absent_ep: assert property (rd_i && sel_i == 2'h3 |=> rdata_i == 8'h00)
        else $error("absent endpoint read not zero");
    a_rdata_holds: assert property ($changed(rdata_i) |-> rvalid_i)
        else $error("read data moved without answer");
    a_strobe_excl: assert property (!(wr_i && rd_i))
        else $error("read and write strobes together");
    // Stall request is never changed by hardware, so it reads back as written
    a_stall_back: assert property (s_rd_present |-> rdata_i[BIT_STALL] == stall_w[$past(sel_i)])
        else $error("stall request lost");
    // Direction bit is stored on every type; only its use is type-gated
    a_dir_back: assert property (s_rd_present |-> rdata_i[BIT_DIR] == dir_w[$past(sel_i)])
        else $error("direction bit lost");
endmodule : usbep_asserts

// File: dv/tb_top.sv
/*
 * Self-checking bench: AHB-Lite master and packet engine around both ends.
 * Assumes controller and endpoint logic share one 100 MHz clock.
 */
`timescale 1ns/10ps
module tb_top;
    import usbep_pkg::*;

    // -------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------
    logic clk_i = 1'h0, arst_n_i = 1'h0;
    logic hsel = 1'h0, hwrite = 1'h0, hready, hresp, irq;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
    usbep_eptype_t [EP_COUNT-1:0] ep_type = {EPT_BULK, EPT_BULK, EPT_CONTROL};
    logic [EP_COUNT-1:0] int_en = 3'h0;
    logic [EP_COUNT-1:0] pp_en = 3'h2;  // Ping-pong on endpoint 1 only
    logic ev_valid = 1'h0, tok_valid = 1'h0, tok_b1 = 1'h0, tok_empty = 1'h0;
    logic [EP_W-1:0] ev_ep = 2'h0, tok_ep = 2'h0, e;
    usbep_ev_t ev_code = EV_NONE;
    usbep_tok_t tok_pid = TOK_OUT;
    logic hs_valid, zlp;
    usbep_hs_t hs_code;
    logic [EP_COUNT-1:0] status_out;
    logic [31:0] seed = 32'h0001_7DBD;
    logic [7:0] v, w;
    usbep_eptype_t ty;
    int miscompares = 0;
    int n_compared = 0;

    usbep_if bus_if();
    usbep_ctl i_usbep_ctl(.clk_i, .arst_n_i, .bus(bus_if), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .irq_o(irq));
    usbep_dev i_usbep_dev(.clk_i, .arst_n_i, .bus(bus_if), .ep_type_i(ep_type),
        .ep_int_en_i(int_en), .pingpong_en_i(pp_en), .ev_valid_i(ev_valid), .ev_ep_i(ev_ep),
        .ev_code_i(ev_code), .tok_valid_i(tok_valid), .tok_ep_i(tok_ep), .tok_pid_i(tok_pid),
        .tok_bank1_i(tok_b1), .tok_fifo_empty_i(tok_empty), .hs_valid_o(hs_valid),
        .hs_code_o(hs_code), .zlp_o(zlp), .status_out_o(status_out));
    usbep_asserts i_usbep_asserts(.clk_i, .arst_n_i, .sel_i(bus_if.sel), .wr_i(bus_if.wr),
        .rd_i(bus_if.rd), .wdata_i(bus_if.wdata), .rdata_i(bus_if.rdata),
        .rvalid_i(bus_if.rvalid), .ep_irq_i(bus_if.ep_irq));

    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] xr();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xr

    // Expected IN handshake; isochronous ignores stall and never NAKs
    function automatic usbep_hs_t exp_in(usbep_eptype_t t, logic stall, logic rdy);
        if (t != EPT_ISO && stall)
            return HS_STALL;
        if (rdy)
            return HS_DATA;
        return (t == EPT_ISO) ? HS_NONE : HS_NAK;
    endfunction : exp_in

    // Bounded wait for hready; a hang ends the run
    task automatic wrdy();
        int n;
        for (n = 0; n == 0 || (hready !== 1'h1 && n < 20); n++)
            @(posedge clk_i);
        chk(hready, 1'h1);
        if (hready !== 1'h1)
            conclude();
    endtask : wrdy

    task automatic ahb(input logic wrt, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wrt;
        wrdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wrdy();
        chk(hresp, 1'h0);
        q = hrdata;
    endtask : ahb

    // Endpoint write, then let the link strobe land
    task automatic ep_wr(input logic [1:0] ep, input logic [7:0] d);
        ahb(1'h1, OFS_ACCESS, {15'h0000, 1'h1, 6'h00, ep, d}, r);
        repeat (2) @(posedge clk_i);
    endtask : ep_wr

    // Endpoint read; the result register settles two cycles after the strobe
    task automatic ep_rd(input logic [1:0] ep, output logic [7:0] o);
        int n;
        ahb(1'h1, OFS_ACCESS, {22'h00_0000, ep, 8'h00}, r);
        repeat (2) @(posedge clk_i);
        n = 0;
        do
        begin
            ahb(1'h0, OFS_RESULT, WORD_ZERO, r);
            n++;
        end
        while (r[RES_BUSY_BIT] !== 1'h0 && n < 20);
        chk(r[RES_BUSY_BIT], 1'h0);
        if (r[RES_BUSY_BIT] !== 1'h0)
            conclude();
        o = r[7:0];
    endtask : ep_rd

    task automatic ev(input logic [1:0] ep, input usbep_ev_t c);
        ev_valid <= 1'h1;
        ev_ep <= ep;
        ev_code <= c;
        @(posedge clk_i);
        ev_valid <= 1'h0;
        repeat (2) @(posedge clk_i);
    endtask : ev

    // Token, then the one-cycle handshake decision
    task automatic tok(input logic [1:0] ep, input usbep_tok_t p, input logic b1,
                       input logic emp, input usbep_hs_t hs, input logic z);
        tok_valid <= 1'h1;
        tok_ep <= ep;
        tok_pid <= p;
        tok_b1 <= b1;
        tok_empty <= emp;
        @(posedge clk_i);
        tok_valid <= 1'h0;
        #1;
        chk(hs_valid, 1'h1);
        chk(hs_code, hs);
        if (hs == HS_DATA)
            chk(zlp, z);
        @(posedge clk_i);
    endtask : tok

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'h1;
        @(posedge clk_i);
        // Reset state and the absent endpoint
        ep_wr(2'h3, 8'hF8);
        for (int i = 0; i < 4; i++)
        begin
            ep_rd(i[1:0], v);
            chk(v, 8'h00);
        end
        ahb(1'h0, 8'h10, WORD_ZERO, r);
        chk(r, WORD_ZERO);
        // Control endpoint: stall, stall sent, interrupt, setup clears
        int_en <= 3'h1;
        ep_wr(2'h0, 8'hA0);
        chk(status_out, 3'h1);
        tok(2'h0, TOK_OUT, 1'h0, 1'h0, HS_STALL, 1'h0);
        ev(2'h0, EV_STALL_SENT);
        ev(2'h0, EV_OUT_B1_STORED);
        ep_rd(2'h0, v);
        chk(v, 8'hA8);
        chk(bus_if.ep_irq, 3'h1);
        ahb(1'h0, OFS_INT_STATUS, WORD_ZERO, r);
        chk(r[INT_EP_LSB], 1'h1);
        chk(irq, 1'h0);
        ahb(1'h1, OFS_INT_MASK, 32'h0000_0002, r);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'h1);
        ahb(1'h1, OFS_INT_STATUS, 32'h0000_0002, r);
        repeat (2) @(posedge clk_i);
        chk(irq, 1'h0);
        tok(2'h0, TOK_SETUP, 1'h0, 1'h0, HS_ACK, 1'h0);
        ep_wr(2'h0, 8'h08);
        ep_rd(2'h0, v);
        chk(v, 8'h00);
        chk(status_out, 3'h0);
        tok(2'h0, TOK_OUT, 1'h0, 1'h0, HS_ACK, 1'h0);
        // Ping-pong bank 1 on endpoint 1
        ev(2'h1, EV_OUT_B1_STORED);
        chk(bus_if.ep_irq[1], 1'h0);
        int_en <= 3'h2;
        repeat (3) @(posedge clk_i);
        chk(bus_if.ep_irq[1], 1'h1);
        tok(2'h1, TOK_OUT, 1'h1, 1'h0, HS_NAK, 1'h0);
        tok(2'h1, TOK_OUT, 1'h0, 1'h0, HS_ACK, 1'h0);
        ep_wr(2'h1, 8'h00);
        tok(2'h1, TOK_OUT, 1'h1, 1'h0, HS_ACK, 1'h0);
        // Every endpoint type on endpoint 2
        for (int t = 0; t < 4; t++)
        begin
            ty = usbep_eptype_t'(t);
            ep_type[2] <= ty;
            ep_wr(2'h2, 8'h20);
            tok(2'h2, TOK_IN, 1'h0, 1'h0, exp_in(ty, 1'h1, 1'h0), 1'h0);
            ev(2'h2, EV_STALL_SENT);
            ep_rd(2'h2, v);
            chk(v[BIT_STALL_SENT_OR_CRC_ERROR], ty != EPT_ISO);
            ep_wr(2'h2, 8'h10);
            ev(2'h2, EV_CRC_ERR);
            tok(2'h2, TOK_IN, 1'h0, 1'h1, HS_DATA, 1'h1);
            ev(2'h2, EV_IN_SENT);
            ep_rd(2'h2, v);
            chk({v[BIT_IN_PACKET_READY], v[BIT_STALL_SENT_OR_CRC_ERROR]}, {ty != EPT_ISO, ty == EPT_ISO});
            ev(2'h2, EV_IN_ACKED);
            ep_rd(2'h2, v);
            chk(v, (ty == EPT_ISO) ? 8'h08 : 8'h00);
            tok(2'h2, TOK_IN, 1'h0, 1'h0, exp_in(ty, 1'h0, 1'h0), 1'h0);
            ep_wr(2'h2, 8'h00);
        end
        // Random firmware writes with read-back and status direction
        for (int i = 0; i < 24; i++)
        begin
            e = 2'(xr() % 3);
            w = 8'(xr()) & 8'hB0;
            ep_wr(e, w);
            chk(status_out[e], ep_type[e] == EPT_CONTROL && w[BIT_DIR]);
            ep_rd(e, v);
            chk(v, w);
        end
        conclude();
    end
endmodule : tb_top
